/* File: rtl/smw_period_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module smw_period_decode (
	// Code
	input  wire logic [3:0]  period_code_in,
	// Decoded
	output logic      [22:0] period_ticks_out,
	output logic             period_legal_out
);

	// ***************************************************
	// Period lookup in oscillator ticks
	// ***************************************************
	always_comb begin
		period_legal_out = 1'b1;
		unique case (period_code_in)
			smw_pkg::PER_8:    period_ticks_out = 23'(8 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_16:   period_ticks_out = 23'(16 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_32:   period_ticks_out = 23'(32 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_64:   period_ticks_out = 23'(64 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_128:  period_ticks_out = 23'(128 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_256:  period_ticks_out = 23'(256 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_1024: period_ticks_out = 23'(1024 * smw_pkg::TICKS_PER_MS);
			smw_pkg::PER_4096: period_ticks_out = 23'(4096 * smw_pkg::TICKS_PER_MS);
			default: begin
				period_ticks_out = 23'(128 * smw_pkg::TICKS_PER_MS);
				period_legal_out = 1'b0;
			end
		endcase
	end

endmodule

`default_nettype wire

/* File: rtl/smw_pkg.sv */
package smw_pkg;

	// ***************************************************
	// Register map
	// ***************************************************
	localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h00;
	localparam int         MODE_MSB              = 7;
	localparam int         MODE_LSB              = 5;
	localparam int         PERIOD_MSB            = 3;
	localparam int         PERIOD_LSB            = 0;

	// ***************************************************
	// Mode and period codes
	// ***************************************************
	localparam logic [2:0] MODE_AUTONOMOUS = 3'h1;
	localparam logic [2:0] MODE_TIMEOUT    = 3'h2;
	localparam logic [2:0] MODE_WINDOW     = 3'h4;

	localparam logic [3:0] PER_8     = 4'h8;
	localparam logic [3:0] PER_16    = 4'h1;
	localparam logic [3:0] PER_32    = 4'h2;
	localparam logic [3:0] PER_64    = 4'hb;
	localparam logic [3:0] PER_128   = 4'h4;
	localparam logic [3:0] PER_256   = 4'hd;
	localparam logic [3:0] PER_1024  = 4'he;
	localparam logic [3:0] PER_4096  = 4'h7;

	// ***************************************************
	// Status and reset cause codes
	// ***************************************************
	localparam logic [1:0] PHASE_OFF    = 2'h0;
	localparam logic [1:0] PHASE_FIRST  = 2'h1;
	localparam logic [1:0] PHASE_SECOND = 2'h2;

	localparam logic [4:0] CAUSE_NONE    = 5'h00;
	localparam logic [4:0] CAUSE_EARLY   = 5'h0e;
	localparam logic [4:0] CAUSE_OVERFLOW = 5'h0f;
	localparam logic [4:0] CAUSE_ILLEGAL = 5'h10;

	// ***************************************************
	// Chip operating modes seen by the watchdog
	// ***************************************************
	typedef enum logic [2:0] {
		SMW_CHIP_OTHER,
		SMW_CHIP_NORMAL,
		SMW_CHIP_STANDBY,
		SMW_CHIP_SLEEP
	} smw_chip_mode_t;

	typedef enum logic [1:0] {
		SMW_EFF_OFF,
		SMW_EFF_TIMEOUT,
		SMW_EFF_WINDOW
	} smw_eff_t;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int TICK_PERIOD_US = 1;
	localparam int CLK_MHZ        = 250;
	localparam int TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;
	localparam int TICKS_PER_MS   = 1000 / TICK_PERIOD_US;

endpackage

/* File: rtl/smw_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Mode code 001/010/100 selects Autonomous/Timeout/Window
// - Window only in Normal; closed-window trigger fails
// - Timeout runs continuously, trigger restarts timer
// - Mode and period change only in Standby
// - Programmed Window acts as Timeout until Normal
// - Mode change in Normal: reset, cause 10000
// - Period codes decode to 8..4096 ms
// - Period shared by modes, default 128 ms
// - Every valid control write is a trigger
// - New mode or period applies at once
// - Illegal code discards access, flags SPI failure
// - Legal codes differ in two bits or more
// - Mode resets to Timeout, Autonomous if development
// - Autonomous in Normal: Timeout, off if development
// - Standby/Sleep act Timeout; Autonomous mostly off
// - Off in forced normal and other modes
// - Enables come from non-volatile configuration
// - Phase status: off, first half, second half
// - Causes 01110 early trigger, 01111 overflow
module smw_watchdog #(
	parameter int TICK_CYCLES = smw_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	// Register access from SPI
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             reg_wr_discard_out,
	// Chip context
	input  wire logic [2:0]  chip_mode_in,
	input  wire logic        forced_normal_enable_in,
	input  wire logic        sw_dev_enable_in,
	input  wire logic        host_irq_line_n_in,
	input  wire logic        spi_fail_irq_enable_in,
	// Results
	output logic             spi_fail_irq_out,
	output logic             wd_fail_out,
	output logic             chip_reset_req_out,
	output logic      [4:0]  reset_cause_code_out,
	output logic      [1:0]  wd_phase_status_out,
	output logic             forced_normal_state_out,
	output logic             sw_dev_state_out
);

	// ***************************************************
	// State
	// ***************************************************
	logic [2:0]  wd_mode_sel;
	logic [3:0]  wd_period_sel;
	logic [22:0] timer;
	logic [15:0] prescale;
	logic        cfg_loaded;
	logic [4:0]  cause;
	logic        fail_pulse;
	logic        rst_pulse;
	logic        spif_pulse;
	logic        discard_pulse;

	logic [2:0]  next_wd_mode_sel;
	logic [3:0]  next_wd_period_sel;
	logic [22:0] next_timer;
	logic [15:0] next_prescale;
	logic        next_cfg_loaded;
	logic [4:0]  next_cause;
	logic        next_fail_pulse;
	logic        next_rst_pulse;
	logic        next_spif_pulse;
	logic        next_discard_pulse;

	smw_pkg::smw_chip_mode_t chip_mode;
	smw_pkg::smw_eff_t       eff;

	logic [22:0] period_ticks;
	logic [22:0] wr_ticks;
	logic        cur_legal;
	logic        wr_period_legal;
	logic        wr_mode_legal;
	logic        ctl_wr;
	logic        tick;

	assign chip_mode = smw_pkg::smw_chip_mode_t'(chip_mode_in);
	assign ctl_wr    = reg_wr_in && (reg_addr_in == smw_pkg::WATCHDOG_CONTROL_ADDR);
	assign tick      = (prescale == 16'(TICK_CYCLES - 1));

	// ***************************************************
	// Period decoding
	// ***************************************************
	smw_period_decode u_cur_period (
		.period_code_in   (wd_period_sel),
		.period_ticks_out (period_ticks),
		.period_legal_out (cur_legal)
	);

	smw_period_decode u_wr_period (
		.period_code_in   (reg_wdata_in[smw_pkg::PERIOD_MSB:smw_pkg::PERIOD_LSB]),
		.period_ticks_out (wr_ticks),
		.period_legal_out (wr_period_legal)
	);

	// One-hot mode codes keep two-bit distance between legal values
	always_comb begin
		wr_mode_legal = 1'b0;
		unique case (reg_wdata_in[smw_pkg::MODE_MSB:smw_pkg::MODE_LSB])
			smw_pkg::MODE_AUTONOMOUS,
			smw_pkg::MODE_TIMEOUT,
			smw_pkg::MODE_WINDOW: wr_mode_legal = 1'b1;
			default:              wr_mode_legal = 1'b0;
		endcase
	end

	// ***************************************************
	// Effective watchdog behaviour
	// ***************************************************
	always_comb begin
		eff = smw_pkg::SMW_EFF_OFF;
		if (!forced_normal_enable_in) begin
			unique case (chip_mode)
				smw_pkg::SMW_CHIP_NORMAL: begin
					if (wd_mode_sel == smw_pkg::MODE_WINDOW)
						eff = smw_pkg::SMW_EFF_WINDOW;
					else if (wd_mode_sel == smw_pkg::MODE_TIMEOUT)
						eff = smw_pkg::SMW_EFF_TIMEOUT;
					else if (!sw_dev_enable_in)
						eff = smw_pkg::SMW_EFF_TIMEOUT;
				end
				smw_pkg::SMW_CHIP_STANDBY,
				smw_pkg::SMW_CHIP_SLEEP: begin
					if (wd_mode_sel != smw_pkg::MODE_AUTONOMOUS)
						eff = smw_pkg::SMW_EFF_TIMEOUT;
					else if (chip_mode == smw_pkg::SMW_CHIP_STANDBY && !host_irq_line_n_in && !sw_dev_enable_in)
						eff = smw_pkg::SMW_EFF_TIMEOUT;
				end
				default: eff = smw_pkg::SMW_EFF_OFF;
			endcase
		end
	end

	// ***************************************************
	// Next-state logic
	// ***************************************************
	always_comb begin
		logic write_ok;
		logic mode_change;
		write_ok            = 1'b0;
		mode_change         = 1'b0;
		next_wd_mode_sel    = wd_mode_sel;
		next_wd_period_sel  = wd_period_sel;
		next_timer          = timer;
		next_prescale       = tick ? 16'h0000 : prescale + 16'h0001;
		next_cfg_loaded     = 1'b1;
		next_cause          = cause;
		next_fail_pulse     = 1'b0;
		next_rst_pulse      = 1'b0;
		next_spif_pulse     = 1'b0;
		next_discard_pulse  = 1'b0;

		// Development strap is sampled after release, not under reset
		if (!cfg_loaded)
			next_wd_mode_sel = sw_dev_enable_in ? smw_pkg::MODE_AUTONOMOUS : smw_pkg::MODE_TIMEOUT;

		if (tick && eff != smw_pkg::SMW_EFF_OFF)
			next_timer = timer + 23'h000001;
		if (eff == smw_pkg::SMW_EFF_OFF)
			next_timer = 23'h000000;

		if (tick && eff != smw_pkg::SMW_EFF_OFF && timer + 23'h000001 >= period_ticks) begin
			next_timer      = 23'h000000;
			next_fail_pulse = 1'b1;
			next_rst_pulse  = 1'b1;
			next_cause      = smw_pkg::CAUSE_OVERFLOW;
		end

		if (ctl_wr && cfg_loaded) begin
			mode_change = reg_wdata_in[smw_pkg::MODE_MSB:smw_pkg::MODE_LSB] != wd_mode_sel;
			if (!wr_mode_legal || !wr_period_legal) begin
				next_discard_pulse = 1'b1;
				next_spif_pulse    = spi_fail_irq_enable_in;
			end else if (chip_mode == smw_pkg::SMW_CHIP_NORMAL && mode_change) begin
				next_rst_pulse = 1'b1;
				next_cause     = smw_pkg::CAUSE_ILLEGAL;
				next_timer     = 23'h000000;
			end else begin
				write_ok = 1'b1;
			end
		end

		if (write_ok) begin
			if (chip_mode == smw_pkg::SMW_CHIP_STANDBY) begin
				next_wd_mode_sel   = reg_wdata_in[smw_pkg::MODE_MSB:smw_pkg::MODE_LSB];
				next_wd_period_sel = reg_wdata_in[smw_pkg::PERIOD_MSB:smw_pkg::PERIOD_LSB];
			end
			if (eff == smw_pkg::SMW_EFF_WINDOW && (timer << 1) < period_ticks) begin
				next_fail_pulse = 1'b1;
				next_rst_pulse  = 1'b1;
				next_cause      = smw_pkg::CAUSE_EARLY;
			end
			next_timer = 23'h000000;
		end
	end

	// ***************************************************
	// Registers
	// ***************************************************
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wd_mode_sel   <= smw_pkg::MODE_TIMEOUT;
			wd_period_sel <= smw_pkg::PER_128;
			timer         <= 23'h000000;
			prescale      <= 16'h0000;
			cfg_loaded    <= 1'b0;
			cause         <= smw_pkg::CAUSE_NONE;
			fail_pulse    <= 1'b0;
			rst_pulse     <= 1'b0;
			spif_pulse    <= 1'b0;
			discard_pulse <= 1'b0;
		end else if (clk_en_in) begin
			wd_mode_sel   <= next_wd_mode_sel;
			wd_period_sel <= next_wd_period_sel;
			timer         <= next_timer;
			prescale      <= next_prescale;
			cfg_loaded    <= next_cfg_loaded;
			cause         <= next_cause;
			fail_pulse    <= next_fail_pulse;
			rst_pulse     <= next_rst_pulse;
			spif_pulse    <= next_spif_pulse;
			discard_pulse <= next_discard_pulse;
		end
	end

	// ***************************************************
	// Outputs
	// ***************************************************
	always_comb begin
		reg_rdata_out = 8'h00;
		if (reg_rd_in && reg_addr_in == smw_pkg::WATCHDOG_CONTROL_ADDR)
			reg_rdata_out = {wd_mode_sel, 1'b0, wd_period_sel};
	end

	always_comb begin
		if (eff == smw_pkg::SMW_EFF_OFF)
			wd_phase_status_out = smw_pkg::PHASE_OFF;
		else if ((timer << 1) < period_ticks)
			wd_phase_status_out = smw_pkg::PHASE_FIRST;
		else
			wd_phase_status_out = smw_pkg::PHASE_SECOND;
	end

	assign reg_wr_discard_out      = discard_pulse;
	assign spi_fail_irq_out        = spif_pulse;
	assign wd_fail_out             = fail_pulse;
	assign chip_reset_req_out      = rst_pulse;
	assign reset_cause_code_out    = cause;
	assign forced_normal_state_out = forced_normal_enable_in && chip_mode == smw_pkg::SMW_CHIP_OTHER;
	assign sw_dev_state_out        = sw_dev_enable_in;

endmodule

`default_nettype wire

/* File: tb/smw_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Host register access
// ****
module smw_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic            wr_out,
	output logic            rd_out,
	output logic      [7:0] addr_out,
	output logic      [7:0] wdata_out
);
	// Idle bus shows inverted data after a write so stale values never look valid
	initial begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 8'hff;
		wdata_out = 8'h00;
	end
	task automatic wr_reg(input logic [7:0] d);
		@(negedge clk_in);
		wr_out = 1'b1;
		addr_out = 8'h00;
		wdata_out = d;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = 8'hff;
		wdata_out = ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		rd_out = 1'b1;
		addr_out = a;
		@(posedge clk_in);
		d = rdata_in;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = 8'hff;
	endtask
endmodule
`default_nettype wire

/* File: tb/smw_watchdog_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module smw_watchdog_bench;
	logic       clk_in = 1'b0;
	logic       reset_n_in = 1'b0;
	logic       clk_en_in = 1'b1;
	logic [2:0] chip_mode_in = 3'h2;
	logic       forced_normal_enable_in = 1'b0;
	logic       sw_dev_enable_in = 1'b0;
	logic       host_irq_line_n_in = 1'b1;
	logic       spi_fail_irq_enable_in = 1'b0;
	logic       reg_wr_in, reg_rd_in, reg_wr_discard_out, spi_fail_irq_out, wd_fail_out, chip_reset_req_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, d;
	logic [4:0] reset_cause_code_out;
	logic [1:0] wd_phase_status_out;
	logic       forced_normal_state_out;
	logic       sw_dev_state_out;
	logic [7:0] bad [2] = '{8'h64, 8'h49};
	logic [3:0] per [8] = '{4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7};
	// Row: chip mode, irq line, dev enable, expect running
	logic [5:0] row [6] = '{6'h14, 6'h11, 6'h18, 6'h0d, 6'h0e, 6'h04};
	int         miscompares = 0;
	int         cmp_count = 0;
	int         n;
	// ****
	// Design and host
	// ****
	smw_watchdog #(.TICK_CYCLES(1)) u_dut (.clk_in, .reset_n_in, .clk_en_in, .reg_wr_in, .reg_rd_in,
		.reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_wr_discard_out, .chip_mode_in,
		.forced_normal_enable_in, .sw_dev_enable_in, .host_irq_line_n_in, .spi_fail_irq_enable_in,
		.spi_fail_irq_out, .wd_fail_out, .chip_reset_req_out, .reset_cause_code_out, .wd_phase_status_out,
		.forced_normal_state_out, .sw_dev_state_out);
	smw_host_model u_host (.clk_in, .rdata_in(reg_rdata_out), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
		.addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
	initial forever #2 clk_in = ~clk_in;
	task chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("Error t=%0t got %h exp %h", $time, g, e);
			miscompares++;
		end
	endtask
	task test_done;
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task run(input int c);
		repeat (c) begin
			@(negedge clk_in);
			chk(wd_fail_out, 1'b0);
		end
	endtask
	task wfail(input int mx, output int k);
		k = 0;
		while (wd_fail_out !== 1'b1) begin
			@(negedge clk_in);
			k++;
			if (k > mx) begin
				chk(1'b0, 1'b1);
				test_done;
			end
		end
	endtask
	initial begin
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		u_host.rd_reg(8'h00, d);
		chk(d, 8'h44);
		u_host.rd_reg(8'h05, d);
		chk(d, 8'h00);
		for (int i = 0; i < 2; i++) begin
			spi_fail_irq_enable_in = i[0];
			u_host.wr_reg(bad[i]);
			chk(reg_wr_discard_out, 1'b1);
			chk(spi_fail_irq_out, i[0]);
		end
		u_host.rd_reg(8'h00, d);
		chk(d, 8'h44);
		for (int i = 0; i < 8; i++) begin
			u_host.wr_reg({3'h2, 1'b0, per[i]});
			chk(reg_wr_discard_out, 1'b0);
			u_host.rd_reg(8'h00, d);
			chk(d, {3'h2, 1'b0, per[i]});
		end
		u_host.wr_reg(8'h48);
		run(6000);
		u_host.wr_reg(8'h48);
		run(6000);
		wfail(3000, n);
		chk(n > 1990 && n < 2010, 1'b1);
		chk(chip_reset_req_out, 1'b1);
		chk(reset_cause_code_out, 5'h0f);
		u_host.wr_reg(8'h88);
		u_host.wr_reg(8'h88);
		chk(wd_fail_out, 1'b0);
		chip_mode_in = 3'h1;
		repeat (2) @(negedge clk_in);
		chk(wd_phase_status_out, 2'h1);
		run(5000);
		chk(wd_phase_status_out, 2'h2);
		u_host.wr_reg(8'h88);
		chk(wd_fail_out, 1'b0);
		chk(wd_phase_status_out, 2'h1);
		u_host.wr_reg(8'h88);
		chk(wd_fail_out, 1'b1);
		chk(reset_cause_code_out, 5'h0e);
		u_host.wr_reg(8'h48);
		chk(chip_reset_req_out, 1'b1);
		chk(reset_cause_code_out, 5'h10);
		u_host.rd_reg(8'h00, d);
		chk(d, 8'h88);
		chip_mode_in = 3'h2;
		u_host.wr_reg(8'h28);
		for (int i = 0; i < 6; i++) begin
			{chip_mode_in, host_irq_line_n_in, sw_dev_enable_in} = row[i][5:1];
			repeat (2) @(negedge clk_in);
			chk(wd_phase_status_out != 2'h0, row[i][0]);
		end
		// Frozen clock enable must swallow an illegal write
		{chip_mode_in, host_irq_line_n_in, sw_dev_enable_in} = 5'h08;
		clk_en_in = 1'b0;
		u_host.wr_reg(8'h64);
		chk(reg_wr_discard_out, 1'b0);
		clk_en_in = 1'b1;
		repeat (2) @(negedge clk_in);
		chk(wd_phase_status_out != 2'h0, 1'b1);
		forced_normal_enable_in = 1'b1;
		chip_mode_in = 3'h0;
		repeat (2) @(negedge clk_in);
		chk(wd_phase_status_out, 2'h0);
		chk(forced_normal_state_out, 1'b1);
		chk(sw_dev_state_out, sw_dev_enable_in);
		forced_normal_enable_in = 1'b0;
		@(negedge clk_in);
		chk(forced_normal_state_out, 1'b0);
		reset_n_in = 1'b0;
		sw_dev_enable_in = 1'b1;
		repeat (8) @(negedge clk_in);
		reset_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		u_host.rd_reg(8'h00, d);
		chk(d, 8'h24);
		chk(sw_dev_state_out, 1'b1);
		test_done;
	end
endmodule
`default_nettype wire

/* File: tb/smw_watchdog_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Watchdog port checks
// ****
module smw_watchdog_monitor (
	// Clock and reset
	input wire logic       clk_in,
	input wire logic       reset_n_in,
	// Inputs
	input wire logic       clk_en_in,
	input wire logic       reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [2:0] chip_mode_in,
	input wire logic       sw_dev_enable_in,
	input wire logic       spi_fail_irq_enable_in,
	// Outputs
	input wire logic       reg_wr_discard_out,
	input wire logic       spi_fail_irq_out,
	input wire logic       wd_fail_out,
	input wire logic       chip_reset_req_out,
	input wire logic [4:0] reset_cause_code_out,
	input wire logic [1:0] wd_phase_status_out,
	input wire logic       sw_dev_state_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	function automatic logic ok(input logic [7:0] d);
		return (d[7:5] inside {3'h1, 3'h2, 3'h4}) &&
			(d[3:0] inside {4'h8, 4'h1, 4'h2, 4'hb, 4'h4, 4'hd, 4'he, 4'h7});
	endfunction
	logic wr;
	assign wr = clk_en_in && reg_wr_in && (reg_addr_in == 8'h00);
	sequence s_bad_wr; wr && !ok(reg_wdata_in); endsequence
	sequence s_ok_wr; wr && ok(reg_wdata_in); endsequence
	property p_disc; s_bad_wr |=> reg_wr_discard_out && !chip_reset_req_out; endproperty
	a_disc: assert property (p_disc) else $error("bad write kept");
	property p_irq; s_bad_wr ##0 spi_fail_irq_enable_in |=> spi_fail_irq_out; endproperty
	a_irq: assert property (p_irq) else $error("no spi irq");
	property p_irq_src; spi_fail_irq_out |-> reg_wr_discard_out && $past(spi_fail_irq_enable_in); endproperty
	a_irq_src: assert property (p_irq_src) else $error("stray spi irq");
	property p_ok; s_ok_wr |=> !reg_wr_discard_out; endproperty
	a_ok: assert property (p_ok) else $error("legal write discarded");
	property p_fail; wd_fail_out |-> chip_reset_req_out && reset_cause_code_out inside {5'h0e, 5'h0f}; endproperty
	a_fail: assert property (p_fail) else $error("fail without reset");
	property p_ill;
		chip_reset_req_out && !wd_fail_out |-> reset_cause_code_out == 5'h10 && $past(wr && chip_mode_in == 3'h1);
	endproperty
	a_ill: assert property (p_ill) else $error("bad illegal reset");
	property p_cause; !$stable(reset_cause_code_out) |-> chip_reset_req_out; endproperty
	a_cause: assert property (p_cause) else $error("cause changed alone");
	// Two cycles of margin, though the effective mode is combinational
	property p_off; (chip_mode_in == 3'h0 || chip_mode_in > 3'h3) [*2] |-> wd_phase_status_out == 2'h0; endproperty
	a_off: assert property (p_off) else $error("watchdog not off");
	property p_phase; wd_phase_status_out != 2'h3; endproperty
	a_phase: assert property (p_phase) else $error("reserved phase");
	property p_sdm; sw_dev_state_out == sw_dev_enable_in; endproperty
	a_sdm: assert property (p_sdm) else $error("dev state wrong");
endmodule
bind smw_watchdog smw_watchdog_monitor u_mon (.clk_in, .reset_n_in, .clk_en_in, .reg_wr_in, .reg_addr_in,
	.reg_wdata_in, .chip_mode_in, .sw_dev_enable_in, .spi_fail_irq_enable_in, .reg_wr_discard_out,
	.spi_fail_irq_out, .wd_fail_out, .chip_reset_req_out, .reset_cause_code_out, .wd_phase_status_out,
	.sw_dev_state_out);
`default_nettype wire
